// ===== core/dwd_pkg.sv
// Package of constants for the digital watchdog downcounter.
// What this block does
// [RULE1] A timeout of the downcounter raises the internal chip reset.
// [RULE2] Software reloads the counter periodically before it expires.
// [RULE3] A fixed strap picks hardware or software activation; software cannot change it.
// [RULE4] Software mode: inactive until the activate bit is set, then active until reset.
// [RULE5] While the watchdog is inactive, STOP mode is allowed.
// [RULE6] Hardware mode: always active, STOP acts as WAIT, oscillator runs, counting continues.
// [RULE7] Hardware mode: the activate bit reads one and ignores clearing writes.
// [RULE8] Leaving STOP on an interrupt lets the counter resume.
// [RULE9] Reset loads the register with 0xfe: activate zero, all other bits one.
// [RULE10] Writing zero to the software-reset bit resets the chip at once.
// [RULE11] The reset fires when counter bit 6 falls; six upper bits set the period.
// [RULE12] Register bits 7..2 map reversed onto counter bits 0..5.
// [RULE13] Sixty-four periods from 3072 to 196608 internal clock cycles.
// [RULE14] With activate zero the counter is a free 7-bit timer without reset.
// [RULE15] The counter is clocked from the internal clock divided by twelve.
// [RULE16] A timeout reloads the counter and holds reset for the stabilisation delay.
// [RULE17] At least 28 instructions run after activation or reset before any reset.
// [RULE18] Reads return the counter in the reversed layout plus the activate bit.
package dwd_pkg;
	localparam int          ADDR_W      = 8;
	localparam logic [7:0]  OFF_WDG     = 8'hd8;
	localparam logic [7:0]  OFF_STAT    = 8'hdc;
	localparam logic [7:0]  WDG_RST     = 8'hfe;
	localparam logic [6:0]  CNT_RST     = 7'h7f;
	localparam logic [6:0]  CNT_FALL    = 7'h40;
	localparam int          BIT_C       = 0;
	localparam int          BIT_SR      = 1;
	localparam int          BIT_T       = 2;
	localparam int          STAT_ACT    = 0;
	localparam int          STAT_HW     = 1;
	localparam int          STAT_WDR    = 2;
	localparam int          DIV_INT     = 12;
	localparam int          PRE_DIV     = 256;
	localparam int          TICK_CYC    = DIV_INT * PRE_DIV;
	localparam logic [11:0] TICK_LAST   = 12'(TICK_CYC - 1);
	localparam logic [10:0] STAB_LAST   = 11'(2048 - 1);
	localparam int          MIN_INSTR   = 28;
	localparam int          GUARD_CYC   = MIN_INSTR * 5 * 13;
	localparam logic [1:0]  OPT_SETTLE  = 2'h3;
	typedef enum logic [2:0] {
		DWD_RUN  = 3'b001,
		DWD_STOP = 3'b010,
		DWD_HOLD = 3'b100
	} dwd_state_t;
endpackage

// ===== core/dwd_watchdog.sv
// Digital watchdog downcounter with an APB register slave.
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
module dwd_watchdog (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic        i_hw_opt,
	input  wire logic        i_stop_req,
	input  wire logic        i_wake,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             o_pready,
	output logic [31:0]      o_prdata,
	output logic             o_pslverr,
	output logic             o_chip_rst,
	output logic             o_osc_stop,
	output logic             o_stop_as_wait,
	output logic             o_active
);
	dwd_pkg::dwd_state_t st_r;
	dwd_pkg::dwd_state_t st_nxt;
	logic [1:0]          opt_sync_r;
	logic [1:0]          opt_cnt_r;
	logic                hw_opt_r;
	logic                opt_vld_r;
	logic                c_r;
	logic [6:0]          cnt_r;
	logic [6:0]          cnt_nxt;
	logic [11:0]         presc_r;
	logic [10:0]         stab_r;
	logic                wdr_r;
	logic                pready_r;
	logic                pslverr_r;
	logic                chip_rst_r;
	logic                osc_stop_r;
	logic                as_wait_r;
	logic                active_r;
	logic [31:0]         prdata_r;
	logic [11:0]         since_r;

	wire sel_wdg  = paddr == dwd_pkg::OFF_WDG;
	wire sel_stat = paddr == dwd_pkg::OFF_STAT;
	wire mapped   = sel_wdg | sel_stat;
	wire acc      = psel & penable & ~pready_r;
	wire fire     = psel & penable & pready_r;
	wire wr_wdg   = fire & pwrite & sel_wdg & (st_r == dwd_pkg::DWD_RUN);
	wire wr_stat  = fire & pwrite & sel_stat;
	// Hardware activation forces the watchdog on; software cannot touch it. [RULE3] [RULE6] [RULE7]
	wire active   = (hw_opt_r & opt_vld_r) | c_r;
	wire running  = st_r == dwd_pkg::DWD_RUN;
	wire tick     = running & (presc_r == dwd_pkg::TICK_LAST);
	// Bit 6 falling while active ends the period. [RULE1] [RULE11]
	wire timeout  = active & tick & ~wr_wdg & (cnt_r == dwd_pkg::CNT_FALL);
	// Clearing the software-reset bit kills the chip at once. [RULE10]
	wire sr_kill  = wr_wdg & ~pwdata[dwd_pkg::BIT_SR];
	wire stab_end = stab_r == dwd_pkg::STAB_LAST;

	logic [5:0] rev_wr;
	logic [5:0] rev_rd;
	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_rev
			// Register bit 7 is the counter LSB, bit 2 the period MSB. [RULE12]
			assign rev_wr[g] = pwdata[7 - g];
			assign rev_rd[g] = cnt_r[5 - g];
		end
	endgenerate

	// Read layout mirrors the write layout. [RULE18]
	wire [7:0] rd_wdg  = {rev_rd, cnt_r[6], active};
	wire [7:0] rd_stat = {5'h00, wdr_r, hw_opt_r, active};
	wire [7:0] rd_val  = sel_wdg ? rd_wdg : rd_stat;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			dwd_pkg::DWD_RUN: begin
				if (timeout | sr_kill) begin
					st_nxt = dwd_pkg::DWD_HOLD;
				end else if (i_stop_req & ~active) begin
					st_nxt = dwd_pkg::DWD_STOP; // [RULE5]
				end
			end
			dwd_pkg::DWD_STOP: begin
				if (i_wake) begin
					st_nxt = dwd_pkg::DWD_RUN; // [RULE8]
				end
			end
			dwd_pkg::DWD_HOLD: begin
				if (stab_end) begin
					st_nxt = dwd_pkg::DWD_RUN; // [RULE16]
				end
			end
			default: st_nxt = dwd_pkg::DWD_RUN;
		endcase
	end

	// A reload also restarts the prescaler, so a fresh period is always whole.
	always_comb begin
		cnt_nxt = cnt_r;
		if (st_r == dwd_pkg::DWD_HOLD) begin
			cnt_nxt = dwd_pkg::CNT_RST; // [RULE16]
		end else if (wr_wdg) begin
			cnt_nxt = {pwdata[dwd_pkg::BIT_SR], rev_wr}; // [RULE2] [RULE12]
		end else if (tick) begin
			cnt_nxt = cnt_r - 7'h01; // [RULE14]
		end
	end

	// The strap is synchronised and then frozen; i_rst clears it and it is sampled again on the fourth cycle after i_rst ends.
	always_ff @(posedge i_ref_clk) begin
		opt_sync_r <= {opt_sync_r[0], i_hw_opt};
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			opt_cnt_r <= 2'h0;
			opt_vld_r <= 1'b0;
			hw_opt_r  <= 1'b0;
		end else if (!opt_vld_r) begin
			opt_cnt_r <= opt_cnt_r + 2'h1;
			if (opt_cnt_r == dwd_pkg::OPT_SETTLE) begin
				opt_vld_r <= 1'b1;
				hw_opt_r  <= opt_sync_r[1]; // [RULE3]
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			st_r <= dwd_pkg::DWD_RUN;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cnt_r <= dwd_pkg::CNT_RST; // [RULE9]
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// The activate bit only ever sets; a chip reset clears it. [RULE4]
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			c_r <= 1'b0;
		end else begin
			c_r <= (st_r == dwd_pkg::DWD_HOLD) ? 1'b0 : c_r | (wr_wdg & pwdata[dwd_pkg::BIT_C]);
		end
	end

	// Divide by twelve, then by 256 per counter step. [RULE13] [RULE15]
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			presc_r <= 12'h000;
		end else begin
			presc_r <= (wr_wdg | tick | ~running) ? 12'h000 : presc_r + 12'h001;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			stab_r <= 11'h000;
		end else begin
			stab_r <= (st_r == dwd_pkg::DWD_HOLD) ? stab_r + 11'h001 : 11'h000;
		end
	end

	// Watchdog-reset flag: a new timeout beats a software clear in the same cycle.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			wdr_r <= 1'b0;
		end else begin
			wdr_r <= timeout | (wdr_r & ~(wr_stat & pwdata[dwd_pkg::STAT_WDR]));
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= acc;
			pslverr_r <= acc & ~mapped;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			prdata_r <= 32'h0000_0000;
		end else begin
			prdata_r <= (acc & ~pwrite & mapped) ? {24'h000000, rd_val} : 32'h0000_0000;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			chip_rst_r <= 1'b0;
			osc_stop_r <= 1'b0;
		end else begin
			chip_rst_r <= st_nxt == dwd_pkg::DWD_HOLD; // [RULE1]
			osc_stop_r <= st_nxt == dwd_pkg::DWD_STOP; // [RULE5]
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			as_wait_r <= 1'b0;
			active_r  <= 1'b0;
		end else begin
			as_wait_r <= running & i_stop_req & active; // [RULE6]
			active_r  <= active;
		end
	end

	assign o_pready       = pready_r;
	assign o_pslverr      = pslverr_r;
	assign o_prdata       = prdata_r;
	assign o_chip_rst     = chip_rst_r;
	assign o_osc_stop     = osc_stop_r;
	assign o_stop_as_wait = as_wait_r;
	assign o_active       = active_r;

	// Helper: cycles since the last activation, reload or reset, saturating.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || wr_wdg || st_r == dwd_pkg::DWD_HOLD) begin
			since_r <= 12'h000;
		end else if (since_r != 12'hfff) begin
			since_r <= since_r + 12'h001;
		end
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	tmo_rst_a: assert property (timeout |=> o_chip_rst) // [RULE1] [RULE11]
		else $error("timeout did not raise chip reset");
	opt_fixed_a: assert property (opt_vld_r && $past(opt_vld_r) |-> $stable(hw_opt_r)) // [RULE3]
		else $error("activation option changed");
	act_sticky_a: assert property (c_r && running |=> c_r || o_chip_rst) // [RULE4]
		else $error("activate bit cleared without reset");
	stop_ok_a: assert property (running && i_stop_req && !active && !sr_kill |=> o_osc_stop) // [RULE5]
		else $error("stop refused while inactive");
	hw_wait_a: assert property (active |-> !o_osc_stop && st_nxt != dwd_pkg::DWD_STOP) // [RULE6]
		else $error("oscillator stopped while active");
	hw_cread_a: assert property ($rose(o_pready) && hw_opt_r && opt_vld_r && !pwrite && sel_wdg
		|-> o_prdata[dwd_pkg::BIT_C]) // [RULE7]
		else $error("activate bit read low in hardware mode");
	wake_run_a: assert property (st_r == dwd_pkg::DWD_STOP && i_wake |=> running) // [RULE8]
		else $error("no resume after wake");
	rst_val_a: assert property ($fell(o_chip_rst) |-> rd_wdg == dwd_pkg::WDG_RST && since_r == 12'h000) // [RULE9] [RULE16]
		else $error("register not at reset value after reset");
	sr_kill_a: assert property (sr_kill |=> o_chip_rst ##1 st_r == dwd_pkg::DWD_HOLD) // [RULE10]
		else $error("software reset bit clear ignored");
	rev_map_a: assert property (wr_wdg && !sr_kill |=> cnt_r[0] == $past(pwdata[7]) && cnt_r[5] == $past(pwdata[2])) // [RULE12]
		else $error("counter bit order wrong");
	step_only_a: assert property (running && !wr_wdg && !tick |=> $stable(cnt_r)) // [RULE13] [RULE15]
		else $error("counter moved between prescaler ticks");
	timer_free_a: assert property (!active && tick && !wr_wdg |=> !o_chip_rst) // [RULE14]
		else $error("timer mode caused a reset");
	stab_len_a: assert property ($fell(o_chip_rst) |-> $past(stab_r) == dwd_pkg::STAB_LAST) // [RULE16]
		else $error("stabilisation hold has wrong length");
	guard_a: assert property (timeout |-> since_r >= 12'(dwd_pkg::GUARD_CYC)) // [RULE17]
		else $error("reset came too soon after reload");
	read_a: assert property ($rose(o_pready) && !pwrite && sel_wdg |-> o_prdata[7:0] == $past(rd_wdg)) // [RULE18]
		else $error("read data differs from counter");

	rdy_pulse_a: assert property (o_pready |=> !o_pready) // [RULE18]
		else $error("ready stood longer than one cycle");
	err_rdy_a: assert property (o_pslverr |-> o_pready) // [RULE18]
		else $error("error without ready");
	rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0000_0000) // [RULE18]
		else $error("read data not zero while idle");
	hold_min_a: assert property ($rose(o_chip_rst) |-> o_chip_rst [*8]) // [RULE16]
		else $error("chip reset hold too short");
	hold_cnt_a: assert property (st_r == dwd_pkg::DWD_HOLD |=> cnt_r == dwd_pkg::CNT_RST) // [RULE16]
		else $error("counter not reloaded in hold");
	hold_deact_a: assert property (st_r == dwd_pkg::DWD_HOLD |=> !c_r) // [RULE4]
		else $error("activate bit survived chip reset");
	stop_inact_a: assert property (o_osc_stop |-> !o_active) // [RULE5]
		else $error("oscillator stopped while active");
	stop_freeze_a: assert property (st_r == dwd_pkg::DWD_STOP |=> $stable(cnt_r)) // [RULE5]
		else $error("counter moved in stop");
	wait_act_a: assert property (o_stop_as_wait |-> o_active) // [RULE6]
		else $error("stop taken as wait while inactive");
	hw_on_a: assert property (hw_opt_r && opt_vld_r |=> o_active) // [RULE6]
		else $error("hardware mode not active");
	act_out_a: assert property (c_r |=> o_active) // [RULE4]
		else $error("activate bit not shown on active output");
	tick_step_a: assert property (tick && !wr_wdg |=> cnt_r == $past(cnt_r) - 7'h01) // [RULE14]
		else $error("counter did not step by one");
	wdr_set_a: assert property (timeout |=> wdr_r) // [RULE1]
		else $error("timeout flag not set");
	presc_clr_a: assert property (wr_wdg |=> presc_r == 12'h000) // [RULE13]
		else $error("reload did not restart prescaler");

	tmo_c: cover property (timeout);
	kill_c: cover property (sr_kill);
	stop_c: cover property (st_r == dwd_pkg::DWD_STOP ##1 running);
	wrap_c: cover property (!active && tick && cnt_r == 7'h00);
	hold_c: cover property ($fell(o_chip_rst));
endmodule // dwd_watchdog

// ===== verif/dwd_watchdog_tb_top.sv
// Self-checking testbench for the watchdog downcounter and its APB register.
`timescale 1ns/10ps
module dwd_watchdog_tb_top;
	logic        i_ref_clk, i_rst, i_hw_opt, i_stop_req, i_wake;
	logic        psel, penable, pwrite, er, saw_wait;
	logic [7:0]  paddr;
	logic [31:0] pwdata, rd, o_prdata;
	logic        o_pready, o_pslverr, o_chip_rst, o_osc_stop, o_stop_as_wait, o_active;
	int          bad_count, cmp_count, cyc, t0, n;

	dwd_watchdog uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_hw_opt(i_hw_opt), .i_stop_req(i_stop_req),
		.i_wake(i_wake), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_chip_rst(o_chip_rst),
		.o_osc_stop(o_osc_stop), .o_stop_as_wait(o_stop_as_wait), .o_active(o_active));

	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	// Sampling at the edge sees the pre-edge value, so one-cycle pulses are never missed.
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		if (o_stop_as_wait === 1'b1) saw_wait <= 1'b1;
	end

	task automatic complete_run;
		$display("Checks made: %0d, mismatches: %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// The request stays put until pready is seen high; data are taken from that same cycle.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge i_ref_clk);
		end while (o_pready !== 1'b1);
		rd = o_prdata;
		er = o_pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask

	task automatic stop_pulse;
		@(posedge i_ref_clk);
		i_stop_req <= 1'b1;
		@(posedge i_ref_clk);
		i_stop_req <= 1'b0;
		@(negedge i_ref_clk);
	endtask

	task automatic do_reset;
		i_rst <= 1'b1;
		repeat (12) @(posedge i_ref_clk);
		i_rst <= 1'b0;
	endtask

	// Measures the chip reset's start from t0 and its length, both bounded.
	task automatic wait_chip(input int lo, input int hi);
		n = 0;
		while (o_chip_rst !== 1'b1 && n < 4000) begin
			@(negedge i_ref_clk);
			n++;
		end
		chk("reset delay in window", 32'h1, 32'(cyc - t0 >= lo && cyc - t0 <= hi));
		n = 0;
		while (o_chip_rst === 1'b1 && n < 3000) begin
			@(negedge i_ref_clk);
			n++;
		end
		chk("reset hold cycles", 32'd2048, 32'(n));
	endtask

	initial begin
		{i_rst, i_hw_opt, i_stop_req, i_wake, psel, penable, pwrite} = 7'h01;
		{paddr, pwdata} = 40'h0;
		{bad_count, cmp_count, cyc, t0, n} = '0;
		saw_wait = 1'b0;
		do_reset();
		rchk(8'hd8, 32'hfe, "register reset value");
		chk("active after reset", 32'h0, 32'(o_active));
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped error", 32'h1, 32'(er));
		chk("unmapped data", 32'h0, rd);
		apb(1'b1, 8'hd8, 32'h82);
		rchk(8'hd8, 32'h82, "reversed readback");
		repeat (3100) @(posedge i_ref_clk);
		rchk(8'hd8, 32'h02, "one step later");
		repeat (3072) @(posedge i_ref_clk);
		rchk(8'hd8, 32'hfc, "timer passes bit six");
		chk("no reset in timer mode", 32'h0, 32'(o_chip_rst));
		stop_pulse();
		chk("stop while inactive", 32'h1, 32'(o_osc_stop));
		@(posedge i_ref_clk);
		i_wake <= 1'b1;
		@(posedge i_ref_clk);
		i_wake <= 1'b0;
		repeat (2) @(negedge i_ref_clk);
		chk("wake leaves stop", 32'h0, 32'(o_osc_stop));
		apb(1'b1, 8'hd8, 32'h03);
		apb(1'b1, 8'hd8, 32'h02);
		t0 = cyc;
		rchk(8'hd8, 32'h03, "activate is sticky");
		chk("active level", 32'h1, 32'(o_active));
		stop_pulse();
		@(negedge i_ref_clk);
		chk("stop taken as wait", 32'h1, 32'(saw_wait));
		chk("oscillator kept", 32'h0, 32'(o_osc_stop));
		wait_chip(3068, 3080);
		rchk(8'hd8, 32'hfe, "reload after timeout");
		chk("inactive after timeout", 32'h0, 32'(o_active));
		apb(1'b1, 8'hd8, 32'hfc);
		t0 = cyc;
		wait_chip(0, 4);
		i_hw_opt <= 1'b1;
		do_reset();
		repeat (6) @(posedge i_ref_clk);
		chk("strap activates", 32'h1, 32'(o_active));
		rchk(8'hd8, 32'hff, "activate reads one");
		apb(1'b1, 8'hd8, 32'hfe);
		rchk(8'hd8, 32'hff, "clear ignored");
		rchk(8'hdc, 32'h03, "status shows strap");
		complete_run();
	end

	initial begin
		repeat (60000) @(posedge i_ref_clk);
		bad_count++;
		complete_run();
	end
endmodule // dwd_watchdog_tb_top
